// ===== lcd_cfg_pkg.sv
// Constants, types and helper functions shared by the LCD configuration and contrast logic.
package lcd_cfg_pkg;

  // ----------------------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_LCD_CONTROL      = 8'h9d;
  localparam logic [7:0] ADDR_CONTRAST_SETPOINT = 8'h9c;
  localparam logic [7:0] RESET_LCD_CONTROL     = 8'h00;
  localparam logic [7:0] RESET_CONTRAST        = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK    = 8'h7f;
  localparam logic [7:0] CONTRAST_WRITE_MASK   = 8'h1f;

  // ----------------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------------
  localparam logic [1:0] DIV_BY_1    = 2'h0;
  localparam logic [1:0] DIV_BY_2    = 2'h1;
  localparam logic [1:0] DIV_BY_4    = 2'h2;
  localparam logic [1:0] DIV_RESVD   = 2'h3;
  localparam logic [1:0] MUX_STATIC  = 2'h0;
  localparam logic [1:0] MUX_TWO     = 2'h1;
  localparam logic [1:0] MUX_THREE   = 2'h2;
  localparam logic [1:0] MUX_FOUR    = 2'h3;
  localparam int         PIN_COUNT   = 32;
  localparam int         PINS_SMALL  = 16;

  // ----------------------------------------------------------------------------
  // Contrast setpoint scale in millivolts
  // ----------------------------------------------------------------------------
  localparam logic [11:0] SETPOINT_MIN_MV  = 12'h76c;
  localparam logic [11:0] SETPOINT_MAX_MV  = 12'he88;
  localparam logic [15:0] SETPOINT_SPAN_MV = 16'h071c;
  localparam logic [15:0] SETPOINT_STEPS   = 16'h001f;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       reserved;
    logic [1:0] lcd_clock_divider;
    logic       blank;
    logic       pins_32;
    logic [1:0] backplane_mux_select;
    logic       bias_half;
  } lcd_control_s;

  typedef struct packed {
    logic master_control_b2;
    logic master_config_b0;
    logic power_control_b3;
    logic battery_monitor_b7;
  } mode_bits_s;

  typedef enum logic [2:0] {
    MODE_BYPASS,
    MODE_MIN_CONTRAST,
    MODE_CONSTANT,
    MODE_AUTO_BYPASS,
    MODE_UNSUPPORTED
  } contrast_mode_e;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  function automatic contrast_mode_e decode_mode(input mode_bits_s b);
    contrast_mode_e m;
    m = MODE_UNSUPPORTED;
    if (!b.master_control_b2 && b.master_config_b0 && !b.power_control_b3 && !b.battery_monitor_b7)
      m = MODE_BYPASS;
    else if (!b.master_control_b2 && b.master_config_b0 && b.power_control_b3 && b.battery_monitor_b7)
      m = MODE_MIN_CONTRAST;
    else if (!b.master_config_b0 && b.power_control_b3 && b.battery_monitor_b7)
      m = MODE_CONSTANT;
    else if (!b.master_config_b0 && !b.power_control_b3 && b.battery_monitor_b7)
      m = MODE_AUTO_BYPASS;
    return m;
  endfunction : decode_mode

  function automatic logic [11:0] setpoint_mv(input logic [4:0] code);
    logic [15:0] scaled;
    scaled = ({11'h000, code} * SETPOINT_SPAN_MV) / SETPOINT_STEPS;
    return SETPOINT_MIN_MV + scaled[11:0];
  endfunction : setpoint_mv

  function automatic logic [1:0] divide_limit(input logic [1:0] ratio);
    logic [1:0] lim;
    case (ratio)
      DIV_BY_2: lim = 2'h1;
      DIV_BY_4: lim = 2'h3;
      default:  lim = 2'h0;
    endcase
    return lim;
  endfunction : divide_limit

  function automatic logic [3:0] mux_mask(input logic [1:0] mux);
    logic [3:0] m;
    case (mux)
      MUX_TWO:   m = 4'h3;
      MUX_THREE: m = 4'h7;
      MUX_FOUR:  m = 4'hf;
      default:   m = 4'h1;
    endcase
    return m;
  endfunction : mux_mask

endpackage : lcd_cfg_pkg

// ===== lcd_tick_divider.sv
// Divider that turns synchronised oscillator edges into the LCD clock enable pulse.
`timescale 1ns/1ps
module lcd_tick_divider (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       osc_rise,
  input  wire logic       gate_on,
  input  wire logic [1:0] div_code,
  output logic            tick
);
  import lcd_cfg_pkg::*;

  logic [1:0] ratio_q;
  logic [1:0] count_q;
  logic       tick_q;

  assign tick = tick_q;

  // The reserved code never reaches the counter; the last good ratio stays in force.
  always_ff @(posedge clk) begin
    if (reset) begin
      ratio_q <= DIV_BY_1;
    end else if (div_code != DIV_RESVD) begin
      ratio_q <= div_code;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= 2'h0;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (osc_rise && gate_on) begin
        if (count_q >= divide_limit(ratio_q)) begin
          count_q <= 2'h0;
          tick_q  <= 1'b1;
        end else begin
          count_q <= count_q + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_tick_needs_gate: assert property (@(posedge clk) disable iff (reset)
    tick_q |-> $past(osc_rise) && $past(gate_on))
    else $error("LCD tick without gated oscillator edge");
  a_reserved_holds: assert property (@(posedge clk) disable iff (reset)
    div_code == DIV_RESVD |=> ratio_q == $past(ratio_q))
    else $error("Reserved divider code changed ratio");
  a_div_one_every: assert property (@(posedge clk) disable iff (reset)
    ratio_q == DIV_BY_1 && osc_rise && gate_on |=> tick_q)
    else $error("Divide by one missed a tick");

endmodule : lcd_tick_divider

// ===== lcd_segment_config.sv
// LCD control and contrast registers, segment masking and contrast mode decode.
`timescale 1ns/1ps
module lcd_segment_config (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RESET,
  input  wire logic [7:0]               SFR_ADDR,
  input  wire logic [7:0]               SFR_WDATA,
  input  wire logic                     SFR_WR,
  input  wire logic                     SFR_RD,
  output logic [7:0]                    SFR_RDATA,
  input  wire logic                     RTC_CLK,
  input  wire logic                     MODULE_CLOCK_GATE,
  input  wire logic                     DISPLAY_ENABLE,
  input  wire lcd_cfg_pkg::mode_bits_s  MODE_BITS,
  input  wire logic                     BATTERY_LOW,
  input  wire logic [127:0]             SEGMENT_DATA,
  output logic [127:0]                  SEGMENT_ON,
  output logic                          LCD_TICK,
  output logic [1:0]                    MUX_MODE,
  output logic                          BIAS_HALF,
  output logic                          PINS_32,
  output logic [4:0]                    CONTRAST_CODE,
  output logic [11:0]                   TARGET_MV,
  output logic                          REGULATE_EN,
  output logic                          CHARGE_PUMP_EN,
  output logic                          SUPPLY_DIRECT
);
  import lcd_cfg_pkg::*;

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  lcd_control_s   ctrl_q;
  logic [4:0]     contrast_q;
  logic [7:0]     rdata_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ctrl_q <= lcd_control_s'(RESET_LCD_CONTROL);
    end else if (SFR_WR && SFR_ADDR == ADDR_LCD_CONTROL) begin
      ctrl_q <= lcd_control_s'(SFR_WDATA & CONTROL_WRITE_MASK);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      contrast_q <= RESET_CONTRAST[4:0];
    end else if (SFR_WR && SFR_ADDR == ADDR_CONTRAST_SETPOINT) begin
      contrast_q <= SFR_WDATA[4:0];
    end
  end

  // Reads are answered one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_q <= 8'h00;
    end else if (SFR_RD) begin
      case (SFR_ADDR)
        ADDR_LCD_CONTROL:       rdata_q <= 8'(ctrl_q) & CONTROL_WRITE_MASK;
        ADDR_CONTRAST_SETPOINT: rdata_q <= {3'h0, contrast_q};
        default:                rdata_q <= 8'h00;
      endcase
    end
  end

  assign SFR_RDATA     = rdata_q;
  assign MUX_MODE      = ctrl_q.backplane_mux_select;
  assign PINS_32       = ctrl_q.pins_32;
  assign CONTRAST_CODE = contrast_q;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic osc_meta_q, osc_sync_q, osc_prev_q;
  logic batt_meta_q, batt_low_q;
  logic osc_rise;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      osc_meta_q  <= 1'b0;
      osc_sync_q  <= 1'b0;
      osc_prev_q  <= 1'b0;
      batt_meta_q <= 1'b0;
      batt_low_q  <= 1'b0;
    end else begin
      osc_meta_q  <= RTC_CLK;
      osc_sync_q  <= osc_meta_q;
      osc_prev_q  <= osc_sync_q;
      batt_meta_q <= BATTERY_LOW;
      batt_low_q  <= batt_meta_q;
    end
  end

  assign osc_rise = osc_sync_q && !osc_prev_q;

  lcd_tick_divider u_divider (
    .clk      (CLK_SYS),
    .reset    (RESET),
    .osc_rise (osc_rise),
    .gate_on  (MODULE_CLOCK_GATE),
    .div_code (ctrl_q.lcd_clock_divider),
    .tick     (LCD_TICK)
  );

  // ----------------------------------------------------------------------------
  // Segment masking
  // ----------------------------------------------------------------------------
  logic [127:0] seg_d;
  logic [127:0] seg_q;
  logic         bias_q;

  always_comb begin
    seg_d = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if ((i < PINS_SMALL || ctrl_q.pins_32) && !ctrl_q.blank && DISPLAY_ENABLE) begin
        seg_d[4*i +: 4] = SEGMENT_DATA[4*i +: 4] & mux_mask(ctrl_q.backplane_mux_select);
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      seg_q  <= '0;
      bias_q <= 1'b0;
    end else begin
      seg_q  <= seg_d;
      bias_q <= ctrl_q.bias_half && ctrl_q.backplane_mux_select != MUX_STATIC;
    end
  end

  assign SEGMENT_ON = seg_q;
  assign BIAS_HALF  = bias_q;

  // ----------------------------------------------------------------------------
  // Contrast control
  // ----------------------------------------------------------------------------
  contrast_mode_e mode_now;
  logic [11:0]    mv_q;
  logic           reg_q, pump_q, direct_q;

  assign mode_now = decode_mode(MODE_BITS);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mv_q <= SETPOINT_MIN_MV;
    end else begin
      mv_q <= setpoint_mv(contrast_q);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      reg_q    <= 1'b0;
      pump_q   <= 1'b0;
      direct_q <= 1'b1;
    end else begin
      case (mode_now)
        MODE_MIN_CONTRAST: begin
          reg_q    <= 1'b0;
          pump_q   <= batt_low_q;
          direct_q <= !batt_low_q;
        end
        MODE_CONSTANT: begin
          reg_q    <= !batt_low_q;
          pump_q   <= batt_low_q;
          direct_q <= 1'b0;
        end
        MODE_AUTO_BYPASS: begin
          reg_q    <= !batt_low_q;
          pump_q   <= 1'b0;
          direct_q <= batt_low_q;
        end
        default: begin
          reg_q    <= 1'b0;
          pump_q   <= 1'b0;
          direct_q <= 1'b1;
        end
      endcase
    end
  end

  assign TARGET_MV      = mv_q;
  assign REGULATE_EN    = reg_q;
  assign CHARGE_PUMP_EN = pump_q;
  assign SUPPLY_DIRECT  = direct_q;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_ctrl_reset_zero: assert property (
    $past(RESET) |-> 8'(ctrl_q) == 8'h00)
    else $error("Control not zero after reset");
  a_reserved_reads_zero: assert property (
    SFR_RD && SFR_ADDR == ADDR_LCD_CONTROL |=> SFR_RDATA == {1'b0, $past(ctrl_q[6:0])})
    else $error("Control readback wrong");
  a_blank_all_off: assert property (
    ctrl_q.blank |=> SEGMENT_ON == '0)
    else $error("Segment lit while blanked");
  a_upper_pins_off: assert property (
    !ctrl_q.pins_32 |=> SEGMENT_ON[127:64] == '0)
    else $error("Upper pins driven in 16-pin size");
  a_static_mask_one: assert property (
    ctrl_q.backplane_mux_select == MUX_STATIC |=> SEGMENT_ON[3:1] == 3'h0)
    else $error("Unused backplane bit used in static");
  a_static_no_bias: assert property (
    ctrl_q.backplane_mux_select == MUX_STATIC |=> !BIAS_HALF)
    else $error("Half bias in static mode");
  a_setpoint_ends: assert property (
    contrast_q == 5'h1f |=> TARGET_MV == SETPOINT_MAX_MV)
    else $error("Top setpoint wrong");
  a_bypass_follows: assert property (
    mode_now == MODE_BYPASS |=> SUPPLY_DIRECT && !REGULATE_EN && !CHARGE_PUMP_EN)
    else $error("Bypass mode not direct");
  a_low_pump_on: assert property (
    (mode_now == MODE_MIN_CONTRAST || mode_now == MODE_CONSTANT) && batt_low_q |=> CHARGE_PUMP_EN)
    else $error("Charge pump not engaged on low battery");
  a_auto_no_pump: assert property (
    mode_now == MODE_AUTO_BYPASS |=> !CHARGE_PUMP_EN && SUPPLY_DIRECT == $past(batt_low_q))
    else $error("Auto-bypass pumped or wrong path");
  a_constant_regulates: assert property (
    mode_now == MODE_CONSTANT && !batt_low_q |=> REGULATE_EN && !SUPPLY_DIRECT)
    else $error("Constant mode not regulating");

  c_blank_seen: cover property (ctrl_q.blank ##1 !ctrl_q.blank);
  c_four_mux: cover property (ctrl_q.backplane_mux_select == MUX_FOUR && ctrl_q.pins_32 && SEGMENT_ON[127]);
  c_pump_engaged: cover property (mode_now == MODE_CONSTANT && CHARGE_PUMP_EN);
  c_auto_direct: cover property (mode_now == MODE_AUTO_BYPASS && SUPPLY_DIRECT);

endmodule : lcd_segment_config

// ===== lcd_glass_model.sv
// Passive LCD glass model that counts the frame clock pulses it receives.
`timescale 1ns/1ps
module lcd_glass_model (
  input  wire logic         clk,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [127:0] segment_on,
  output logic      [15:0]  tick_count,
  output logic      [7:0]   lit_count
);
  always_ff @(posedge clk) begin
    if (clear) begin
      tick_count <= 16'h0000;
    end else if (tick) begin
      tick_count <= tick_count + 16'h0001;
    end
  end
  always_comb lit_count = 8'($countones(segment_on));
endmodule : lcd_glass_model

// ===== lcd_segment_config_contrast_test.sv
// Self-checking testbench for the LCD configuration and contrast block.
`timescale 1ns/1ps
module lcd_segment_config_contrast_test;
  import lcd_cfg_pkg::*;
  // ----------------------------------------------------------------------------
  // Signals, design and glass model
  // ----------------------------------------------------------------------------
  logic         clk_sys = 1'b0;
  logic         reset, sfr_wr, sfr_rd, rtc_clk, gate, disp_en, batt_low, cnt_clear;
  logic         bias_half, pins_32, reg_en, pump_en, direct, lcd_tick;
  logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata, w, lit_count;
  mode_bits_s   mode_bits;
  logic [127:0] seg_data, seg_on;
  logic [1:0]   mux_mode;
  logic [4:0]   contrast_code;
  logic [11:0]  target_mv;
  logic [15:0]  tick_count;
  logic [31:0]  seed, v;
  int           failures, cmp_count, cycles;

  always #2.5 clk_sys = ~clk_sys;

  lcd_segment_config lcd_segment_config_i (
    .CLK_SYS(clk_sys), .RESET(reset), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr),
    .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .RTC_CLK(rtc_clk), .MODULE_CLOCK_GATE(gate),
    .DISPLAY_ENABLE(disp_en), .MODE_BITS(mode_bits), .BATTERY_LOW(batt_low), .SEGMENT_DATA(seg_data),
    .SEGMENT_ON(seg_on), .LCD_TICK(lcd_tick), .MUX_MODE(mux_mode), .BIAS_HALF(bias_half), .PINS_32(pins_32),
    .CONTRAST_CODE(contrast_code), .TARGET_MV(target_mv), .REGULATE_EN(reg_en),
    .CHARGE_PUMP_EN(pump_en), .SUPPLY_DIRECT(direct)
  );

  lcd_glass_model lcd_glass_model_i (
    .clk(clk_sys), .clear(cnt_clear), .tick(lcd_tick), .segment_on(seg_on), .tick_count(tick_count),
    .lit_count(lit_count)
  );

  // ----------------------------------------------------------------------------
  // Helpers and reference model
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  function automatic logic [127:0] seg_exp(input logic [7:0] c, input logic en, input logic [127:0] d);
    logic [127:0] r;
    r = '0;
    for (int p = 0; p < 32; p++) begin
      if ((p < 16 || c[3]) && en && !c[4]) r[4*p+:4] = d[4*p+:4] & 4'((2 << c[2:1]) - 1);
    end
    return r;
  endfunction : seg_exp

  // Returns regulate, charge pump and direct supply for mode bits and battery state.
  function automatic logic [2:0] mode_exp(input logic [3:0] b, input logic low);
    if (b == 4'b0100) return 3'b001;
    if (b == 4'b0111) return {1'b0, low, !low};
    if (b[2:0] == 3'b011) return {!low, low, 1'b0};
    if (b[2:0] == 3'b001) return {!low, 1'b0, low};
    return 3'b001;
  endfunction : mode_exp

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk128(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk128

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    cyc(1);
    chk16({8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rd

  task automatic rtc_rises(input int n);
    repeat (n) begin
      rtc_clk = 1'b1;
      cyc(4);
      rtc_clk = 1'b0;
      cyc(4);
    end
  endtask : rtc_rises

  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    seed = 32'hec1131ba;
    {reset, sfr_wr, sfr_rd, rtc_clk, gate, disp_en, batt_low, cnt_clear} = 8'h80;
    {sfr_addr, sfr_wdata, seg_data} = '0;
    mode_bits = '0;
    cyc(6);
    reset = 1'b0;
    rd(ADDR_LCD_CONTROL, RESET_LCD_CONTROL);
    rd(ADDR_CONTRAST_SETPOINT, RESET_CONTRAST);
    chk16({12'h000, mux_mode, bias_half, pins_32}, 16'h0000);
    chk16({4'h0, target_mv}, 16'h076c);
    for (int k = 0; k < 16; k++) begin
      v = xorshift();
      disp_en = 1'b0;
      wr(ADDR_LCD_CONTROL, {1'b0, v[6:0]});
      seg_data = {xorshift(), xorshift(), xorshift(), xorshift()};
      disp_en = v[8] | k[0];
      cyc(2);
      rd(ADDR_LCD_CONTROL, v[7:0] & CONTROL_WRITE_MASK);
      chk16({13'h0, mux_mode, pins_32}, {13'h0, v[2:1], v[3]});
      chk16({15'h0, bias_half}, {15'h0, v[0] & (v[2:1] != 2'h0)});
      chk128(seg_on, seg_exp(v[7:0], disp_en, seg_data));
      chk16({8'h00, lit_count}, 16'($countones(seg_exp(v[7:0], disp_en, seg_data))));
    end
    for (int k = 0; k < 8; k++) begin
      v = xorshift();
      w = (k == 0) ? 8'hff : (k == 1) ? 8'he0 : v[7:0];
      wr(ADDR_CONTRAST_SETPOINT, w);
      cyc(2);
      rd(ADDR_CONTRAST_SETPOINT, w & CONTRAST_WRITE_MASK);
      chk16({11'h0, contrast_code}, {11'h0, w[4:0]});
      chk16({4'h0, target_mv}, 16'(1900 + int'(w[4:0]) * 1820 / 31));
    end
    wr(8'h9e, 8'h55);
    rd(8'h9e, 8'h00);
    for (int m = 0; m < 32; m++) begin
      mode_bits = mode_bits_s'(4'(m >> 1));
      batt_low = m[0];
      cyc(5);
      chk16({13'h0, reg_en, pump_en, direct},
            {13'h0, mode_exp(4'(m >> 1), m[0])});
    end
    gate = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_LCD_CONTROL, {1'b0, 2'(k), 5'h00});
      rtc_rises(4);
      cyc(8);
      cnt_clear = 1'b1;
      cyc(1);
      cnt_clear = 1'b0;
      rtc_rises(16);
      cyc(8);
      chk16(tick_count, 16'(16 >> ((k == 3) ? 2 : k)));
    end
    gate = 1'b0;
    cnt_clear = 1'b1;
    cyc(1);
    cnt_clear = 1'b0;
    rtc_rises(8);
    cyc(8);
    chk16(tick_count, 16'h0000);
    wrap_up();
  end
endmodule : lcd_segment_config_contrast_test
